// File: hdl/ppoc_consts.svh
// Constants for downstream port power and overcurrent control.
// Assumes a 40 MHz pclk and APB register access.
`ifndef PPOC_CONSTS_SVH
`define PPOC_CONSTS_SVH

// -------------------------------------------------------------------
// Sizes and timing
// -------------------------------------------------------------------
`define PPOC_NPORT      6
`define PPOC_CLK_NS     25
`define PPOC_TICK_NS    1000000
`define PPOC_DIV_W      16

// -------------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------------
`define PPOC_A_CTRL     8'h00
`define PPOC_A_PWR      8'h04
`define PPOC_A_CHG      8'h08
`define PPOC_A_OCSTAT   8'h0C
`define PPOC_A_MINW     8'h10
`define PPOC_A_DBLW     8'h14
`define PPOC_A_LOCK     8'h18
`define PPOC_A_PINS     8'h1C

// -------------------------------------------------------------------
// Field positions and reset values
// -------------------------------------------------------------------
`define PPOC_CTRL_GANG  0
`define PPOC_CTRL_CPU   1
`define PPOC_MINW_RST   4'h5
`define PPOC_DBLW_RST   8'h14
`define PPOC_LOCK_RST   8'h0A

`endif

// File: hdl/ppoc_pkg.sv
// Types for downstream port power and overcurrent control.
// Assumes ppoc_consts.svh is on the include path.
`include "ppoc_consts.svh"

package ppoc_pkg;

    // Filter settings shared by every detector
    typedef struct packed {
        logic [3:0] min_w;
        logic [7:0] dbl_win;
        logic [7:0] lockout;
    } ppoc_cfg_s;

    // Drive of a group of open-drain pins
    typedef struct packed {
        logic [`PPOC_NPORT-1:0] out;
        logic [`PPOC_NPORT-1:0] oe_n;
        logic [`PPOC_NPORT-1:0] pu_en;
    } ppoc_pins_s;

    // Detector states, one-hot
    typedef enum logic [3:0] {
        PPOC_OFF  = 4'b0001,
        PPOC_LOCK = 4'b0010,
        PPOC_ARM  = 4'b0100,
        PPOC_HOLD = 4'b1000
    } ppoc_det_e;

endpackage

// File: hdl/ppoc_det.sv
// Overcurrent filter for one sensed pin: lockout, single and double pulse.
// Assumes a synchronised pin level and a one-cycle 1 ms tick.
`timescale 1ns/1ps
`include "ppoc_consts.svh"

module ppoc_det (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Control
    input  wire logic               tick,
    input  wire logic               en,
    input  wire logic               pin_low,
    input  wire ppoc_pkg::ppoc_cfg_s cfg,
    // Result
    output logic                    trip_ff
);

    ppoc_pkg::ppoc_det_e state_ff;
    ppoc_pkg::ppoc_det_e nxt_state;
    logic [7:0]          lock_cnt_ff;
    logic [3:0]          run_ff;
    logic [7:0]          win_ff;
    logic                grp_ff;
    logic                prev_low_ff;
    logic                armed;
    logic                grp_start;
    logic                run_hit;
    logic                dbl_hit;
    logic                trip;

    // -------------------------------------------------------------------
    // Trip decision
    // -------------------------------------------------------------------
    assign armed     = (state_ff == ppoc_pkg::PPOC_ARM);
    assign grp_start = pin_low && !prev_low_ff;
    assign run_hit   = (5'({1'b0, run_ff}) + 5'h01)
                       >= {1'b0, cfg.min_w};
    assign dbl_hit   = grp_start && grp_ff && (win_ff != 8'h00);
    // Only sampled while armed, so power-up dips never count
    assign trip = armed && tick && pin_low && (run_hit || dbl_hit);

    // -------------------------------------------------------------------
    // State machine
    // -------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ppoc_pkg::PPOC_OFF: begin
                if (en) nxt_state = ppoc_pkg::PPOC_LOCK;
            end
            ppoc_pkg::PPOC_LOCK: begin
                if (!en) nxt_state = ppoc_pkg::PPOC_OFF;
                else if (tick && lock_cnt_ff <= 8'h01)
                    nxt_state = ppoc_pkg::PPOC_ARM;
            end
            ppoc_pkg::PPOC_ARM: begin
                if (!en) nxt_state = ppoc_pkg::PPOC_OFF;
                else if (trip) nxt_state = ppoc_pkg::PPOC_HOLD;
            end
            ppoc_pkg::PPOC_HOLD: begin
                // Rearm only through a power cycle
                if (!en) nxt_state = ppoc_pkg::PPOC_OFF;
            end
            default: nxt_state = ppoc_pkg::PPOC_OFF;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state_ff <= ppoc_pkg::PPOC_OFF;
        else state_ff <= nxt_state;
    end

    // Lockout counter, loaded while off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lock_cnt_ff <= `PPOC_LOCK_RST;
        else if (state_ff == ppoc_pkg::PPOC_OFF) lock_cnt_ff <= cfg.lockout;
        else if (state_ff == ppoc_pkg::PPOC_LOCK && tick)
            lock_cnt_ff <= lock_cnt_ff - 8'h01;
    end

    // Run of consecutive low samples, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) run_ff <= 4'h0;
        else if (!armed) run_ff <= 4'h0;
        else if (tick) begin
            if (!pin_low) run_ff <= 4'h0;
            else if (run_ff != 4'hF) run_ff <= run_ff + 4'h1;
        end
    end

    // Rolling window opened by the first group of lows
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_ff      <= 8'h00;
            grp_ff      <= 1'b0;
            prev_low_ff <= 1'b0;
        end else if (!armed) begin
            win_ff      <= 8'h00;
            grp_ff      <= 1'b0;
            prev_low_ff <= 1'b0;
        end else if (tick) begin
            prev_low_ff <= pin_low;
            if (grp_start && !dbl_hit) begin
                grp_ff <= 1'b1;
                win_ff <= cfg.dbl_win;
            end else if (win_ff != 8'h00) begin
                win_ff <= win_ff - 8'h01;
                if (win_ff == 8'h01) grp_ff <= 1'b0;
            end
        end
    end

    // Registered one-cycle trip pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) trip_ff <= 1'b0;
        else trip_ff <= trip;
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_trip_needs_arm: assert property (
        @(posedge pclk) disable iff (!presetn)
        trip_ff |-> $past(state_ff) == ppoc_pkg::PPOC_ARM
    ) else $error("trip outside armed state");

    a_trip_on_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        trip_ff |-> $past(pin_low) && $past(tick)
    ) else $error("trip without a low sample on tick");

    a_hold_after_trip: assert property (
        @(posedge pclk) disable iff (!presetn)
        trip_ff && en |-> state_ff == ppoc_pkg::PPOC_HOLD ##1 !trip_ff
    ) else $error("detector not held after trip");

    a_off_when_dis: assert property (
        @(posedge pclk) disable iff (!presetn)
        !en && state_ff != ppoc_pkg::PPOC_OFF |=>
            state_ff == ppoc_pkg::PPOC_OFF
    ) else $error("detector not stopped on power off");

    a_lock_on_rise: assert property (
        @(posedge pclk) disable iff (!presetn)
        state_ff == ppoc_pkg::PPOC_OFF && en |=>
            state_ff == ppoc_pkg::PPOC_LOCK
    ) else $error("no lockout after power on");

endmodule

// File: hdl/ppoc_ctrl.sv
// Downstream port power switching and overcurrent sensing, six ports.
// Assumes APB master on pclk; pins are open drain with external pull.
`timescale 1ns/1ps
`include "ppoc_consts.svh"

module ppoc_ctrl #(
    parameter int TICK_CYCLES = `PPOC_TICK_NS / `PPOC_CLK_NS
) (
    // APB slave
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Hub control logic side
    input  wire logic [`PPOC_NPORT-1:0] hub_pwr_req,
    input  wire logic [`PPOC_NPORT-1:0] hub_oc_clr,
    output logic [`PPOC_NPORT-1:0]      oc_flag,
    // Per-port control pins
    input  wire logic [`PPOC_NPORT-1:0] port_control_pin_in,
    output logic [`PPOC_NPORT-1:0]      port_control_pin_out,
    output logic [`PPOC_NPORT-1:0]      port_control_pin_oe_n,
    output logic [`PPOC_NPORT-1:0]      port_control_pin_pu_en,
    // Shared gang pin
    input  wire logic                   shared_power_pin_in,
    output logic                        shared_power_pin_out,
    output logic                        shared_power_pin_oe_n,
    output logic                        shared_power_pin_pu_en
);

    localparam int NP = `PPOC_NPORT;

    logic [NP-1:0]           oc_ff;
    logic [NP-1:0]           cpu_pwr_ff;
    logic [NP-1:0]           chg_ff;
    logic                    gang_ff;
    logic                    cpu_own_ff;
    ppoc_pkg::ppoc_cfg_s     cfg_ff;
    logic [31:0]             rdata_ff;
    logic [NP:0]             sync1_ff;
    logic [NP:0]             sync2_ff;
    logic [`PPOC_DIV_W-1:0]  div_ff;
    logic                    tick_ff;
    logic [NP-1:0]           pwr_req;
    logic [NP-1:0]           port_on;
    logic                    gang_on;
    logic [NP:0]             det_en;
    logic [NP:0]             trip;
    logic [NP-1:0]           oc_set;
    logic [NP-1:0]           oc_clr;
    logic                    wr_en;
    logic                    rd_setup;
    ppoc_pkg::ppoc_pins_s    port_drv;

    // -------------------------------------------------------------------
    // Address decode
    // -------------------------------------------------------------------
    // Shared by the write enable and the error answer
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `PPOC_A_CTRL, `PPOC_A_PWR, `PPOC_A_CHG, `PPOC_A_OCSTAT,
            `PPOC_A_MINW, `PPOC_A_DBLW, `PPOC_A_LOCK,
            `PPOC_A_PINS: is_mapped = 1'b1;
            default:      is_mapped = 1'b0;
        endcase
    endfunction

    // Zero-wait slave; write lands at the access edge
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !is_mapped(paddr);
    assign wr_en    = psel && penable && pwrite && is_mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;
    assign prdata   = rdata_ff;

    // -------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------
    // Gang bit can be rewritten over APB at any time, with no write-once lock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gang_ff    <= 1'b0;
            cpu_own_ff <= 1'b0;
        end else if (wr_en && paddr == `PPOC_A_CTRL) begin
            gang_ff    <= pwdata[`PPOC_CTRL_GANG];
            cpu_own_ff <= pwdata[`PPOC_CTRL_CPU];
        end
    end

    // Processor power requests and charging indication
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_pwr_ff <= '0;
            chg_ff     <= '0;
        end else if (wr_en && paddr == `PPOC_A_PWR) begin
            cpu_pwr_ff <= pwdata[NP-1:0];
        end else if (wr_en && paddr == `PPOC_A_CHG) begin
            chg_ff <= pwdata[NP-1:0];
        end
    end

    // Filter timing; zero window or lockout is software's mistake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff.min_w   <= `PPOC_MINW_RST;
            cfg_ff.dbl_win <= `PPOC_DBLW_RST;
            cfg_ff.lockout <= `PPOC_LOCK_RST;
        end else if (wr_en && paddr == `PPOC_A_MINW) begin
            // Values above 5 ms are clamped to keep the documented range
            cfg_ff.min_w <= (pwdata[3:0] > `PPOC_MINW_RST) ?
                            `PPOC_MINW_RST : pwdata[3:0];
        end else if (wr_en && paddr == `PPOC_A_DBLW) begin
            cfg_ff.dbl_win <= pwdata[7:0];
        end else if (wr_en && paddr == `PPOC_A_LOCK) begin
            cfg_ff.lockout <= pwdata[7:0];
        end
    end

    // Read data captured in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rdata_ff <= 32'h0000_0000;
        else if (rd_setup) begin
            case (paddr)
                `PPOC_A_CTRL:   rdata_ff <= {30'h0, cpu_own_ff, gang_ff};
                `PPOC_A_PWR:    rdata_ff <= {26'h0, cpu_pwr_ff};
                `PPOC_A_CHG:    rdata_ff <= {26'h0, chg_ff};
                `PPOC_A_OCSTAT: rdata_ff <= {26'h0, oc_ff};
                `PPOC_A_MINW:   rdata_ff <= {28'h0, cfg_ff.min_w};
                `PPOC_A_DBLW:   rdata_ff <= {24'h0, cfg_ff.dbl_win};
                `PPOC_A_LOCK:   rdata_ff <= {24'h0, cfg_ff.lockout};
                `PPOC_A_PINS:   rdata_ff <= {25'h0, sync2_ff};
                default:        rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // 1 ms tick
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == `PPOC_DIV_W'(TICK_CYCLES - 1)) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + `PPOC_DIV_W'(1);
            tick_ff <= 1'b0;
        end
    end

    // -------------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------------
    // Bit NP is the shared pin; only the second stage feeds logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= '1;
            sync2_ff <= '1;
        end else begin
            sync1_ff <= {shared_power_pin_in, port_control_pin_in};
            sync2_ff <= sync1_ff;
        end
    end

    // -------------------------------------------------------------------
    // Power steering and pin drive
    // -------------------------------------------------------------------
    // Charging supply shows as a released pin on that port, or on the shared pin when ganged
    assign pwr_req = (cpu_own_ff ? cpu_pwr_ff : hub_pwr_req)
                     | chg_ff;
    assign gang_on = gang_ff && (|pwr_req);
    assign port_on = gang_ff ? '0 : pwr_req;
    assign det_en  = {gang_on, port_on};

    // Off: driven low, pull-up off; on: released, pull-up on
    always_comb begin
        port_drv.out   = '0;
        port_drv.oe_n  = port_on;
        port_drv.pu_en = port_on;
    end

    assign port_control_pin_out   = port_drv.out;
    assign port_control_pin_oe_n  = port_drv.oe_n;
    assign port_control_pin_pu_en = port_drv.pu_en;
    assign shared_power_pin_out   = 1'b0;
    assign shared_power_pin_oe_n  = gang_on;
    assign shared_power_pin_pu_en = gang_on;

    // -------------------------------------------------------------------
    // Detectors, one per port plus the shared pin
    // -------------------------------------------------------------------
    // External switch pulls low on fault, so low means overcurrent
    genvar gi;
    generate
        for (gi = 0; gi <= NP; gi++) begin : g_det
            ppoc_det u_det (
                .pclk    (pclk),
                .presetn (presetn),
                .tick    (tick_ff),
                .en      (det_en[gi]),
                .pin_low (!sync2_ff[gi]),
                .cfg     (cfg_ff),
                .trip_ff (trip[gi])
            );
        end
    endgenerate

    // -------------------------------------------------------------------
    // Sticky overcurrent flags
    // -------------------------------------------------------------------
    assign oc_set = trip[NP-1:0] | {NP{trip[NP]}};
    assign oc_clr = hub_oc_clr |
                    ((wr_en && paddr == `PPOC_A_OCSTAT) ?
                     pwdata[NP-1:0] : '0);

    // Set wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) oc_ff <= '0;
        else oc_ff <= (oc_ff & ~oc_clr) | oc_set;
    end

    assign oc_flag = oc_ff;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_off_pin_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((~port_on) & (port_control_pin_oe_n | port_control_pin_pu_en))
            == '0
    ) else $error("unpowered port pin not driven low");

    a_on_pin_free: assert property (
        @(posedge pclk) disable iff (!presetn)
        (port_on & ~(port_control_pin_oe_n & port_control_pin_pu_en))
            == '0
    ) else $error("powered port pin not released");

    a_gang_all_flags: assert property (
        @(posedge pclk) disable iff (!presetn)
        trip[NP] |=> oc_flag == {NP{1'b1}}
    ) else $error("ganged trip did not flag all ports");

    a_flag_sticky: assert property (
        @(posedge pclk) disable iff (!presetn)
        oc_flag[0] && !oc_clr[0] |=> oc_flag[0]
    ) else $error("overcurrent flag lost without clear");

    a_gang_idle_ports: assert property (
        @(posedge pclk) disable iff (!presetn)
        gang_ff |-> port_control_pin_oe_n == '0
    ) else $error("port pins active in ganged mode");

    a_tick_spacing: assert property (
        @(posedge pclk) disable iff (!presetn)
        tick_ff |=> !tick_ff [*2]
    ) else $error("tick pulses too close");

endmodule

// File: test/ppoc_sw_model.sv
// External power switch model for all six port pins and the gang pin.
// Assumes the line carries an external pull-up, so a released pin is high.
`timescale 1ns/1ps

module ppoc_sw_model #(
    parameter int N = 7
) (
    // Device side drive
    input  wire logic [N-1:0] oe_n,
    input  wire logic [N-1:0] pu_en,
    // Fault commands from the bench
    input  wire logic [N-1:0] fault,
    // Wire level seen by the device
    output logic [N-1:0]      lvl
);
    // ---------------------------------------------------------------
    // Wire resolution
    // ---------------------------------------------------------------
    // Device drive wins; a faulted switch sinks the released line
    always_comb begin
        for (int i = 0; i < N; i++) begin
            if (!oe_n[i])
                lvl[i] = 1'b0;
            else if (fault[i])
                lvl[i] = 1'b0;
            else
                lvl[i] = 1'b1;  // Pull-up holds it even if pu_en is off
        end
    end
endmodule

// File: test/tb_top.sv
// Self-checking bench for port power and overcurrent control.
// Assumes design files and the switch model are compiled before it.
`timescale 1ns/1ps
`include "ppoc_consts.svh"

module tb_top;
    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    localparam int TK = 20;  // Short tick keeps the run brief
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, pready, pslverr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [5:0]  hub_pwr_req = 6'h00, hub_oc_clr = 6'h00, oc_flag;
    logic [5:0]  port_control_pin_in, port_control_pin_out;
    logic [5:0]  port_control_pin_oe_n, port_control_pin_pu_en;
    logic        shared_power_pin_in, shared_power_pin_out;
    logic        shared_power_pin_oe_n, shared_power_pin_pu_en, er;
    logic [6:0]  fault = 7'h00, lvl;
    int          error_cnt = 0;
    int          check_count = 0;

    always #12.5 pclk = ~pclk;

    ppoc_ctrl #(.TICK_CYCLES(TK)) ppoc_ctrl_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hub_pwr_req, .hub_oc_clr, .oc_flag,
        .port_control_pin_in, .port_control_pin_out,
        .port_control_pin_oe_n, .port_control_pin_pu_en,
        .shared_power_pin_in, .shared_power_pin_out,
        .shared_power_pin_oe_n, .shared_power_pin_pu_en);

    ppoc_sw_model #(.N(7)) ppoc_sw_model_inst (
        .oe_n({shared_power_pin_oe_n, port_control_pin_oe_n}),
        .pu_en({shared_power_pin_pu_en, port_control_pin_pu_en}),
        .fault(fault), .lvl(lvl));

    assign port_control_pin_in = lvl[5:0];
    assign shared_power_pin_in = lvl[6];

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits on pready, only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Write lands on the access edge; callers look one edge later
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic wt(input int t);
        repeat (t * TK) @(posedge pclk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    // Hang guard, well beyond the roughly 1100 cycles of the tests
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({port_control_pin_oe_n, port_control_pin_pu_en}),
            32'h0);
        rchk(`PPOC_A_CTRL, 32'h0);
        rchk(`PPOC_A_MINW, 32'h5);
        rchk(`PPOC_A_DBLW, 32'h14);
        rchk(`PPOC_A_LOCK, 32'h0A);
        rchk(`PPOC_A_PINS, 32'h0);
        apb(1'b1, 8'h40, 32'h1);
        chk(32'(er), 32'h1);
        apb(1'b1, `PPOC_A_MINW, 32'h9);
        rchk(`PPOC_A_MINW, 32'h5);
        // Single pulse on port 0; lows inside lockout must not count
        apb(1'b1, `PPOC_A_MINW, 32'h2);
        apb(1'b1, `PPOC_A_LOCK, 32'h3);
        hub_pwr_req <= 6'h01;
        fault <= 7'h01;
        @(posedge pclk);
        chk(32'({port_control_pin_oe_n[0], port_control_pin_pu_en[0]}),
            32'h3);
        repeat (30) @(posedge pclk);
        fault <= 7'h00;
        wt(4);
        chk(32'(oc_flag), 32'h0);
        fault <= 7'h01;
        wt(5);
        chk(32'(oc_flag), 32'h1);
        fault <= 7'h00;
        apb(1'b1, `PPOC_A_OCSTAT, 32'h1);
        chk(32'(oc_flag), 32'h0);
        // Detector stays held until power is cycled
        fault <= 7'h01;
        wt(5);
        chk(32'(oc_flag), 32'h0);
        fault <= 7'h00;
        hub_pwr_req <= 6'h00;
        @(posedge pclk);
        chk(32'({port_control_pin_oe_n, port_control_pin_pu_en}),
            32'h0);
        chk(32'({shared_power_pin_out, port_control_pin_out}),
            32'h0);
        // Two short lows on port 1 inside the window
        apb(1'b1, `PPOC_A_MINW, 32'h5);
        hub_pwr_req <= 6'h02;
        wt(5);
        fault <= 7'h02;
        repeat (25) @(posedge pclk);
        fault <= 7'h00;
        wt(3);
        chk(32'(oc_flag), 32'h0);
        fault <= 7'h02;
        repeat (25) @(posedge pclk);
        fault <= 7'h00;
        wt(2);
        chk(32'(oc_flag), 32'h2);
        // Processor ownership and charging indication
        hub_pwr_req <= 6'h00;
        apb(1'b1, `PPOC_A_OCSTAT, 32'h3F);
        apb(1'b1, `PPOC_A_CTRL, 32'h2);
        apb(1'b1, `PPOC_A_PWR, 32'h4);
        chk(32'(port_control_pin_oe_n), 32'h04);
        apb(1'b1, `PPOC_A_CHG, 32'h8);
        chk(32'(port_control_pin_oe_n), 32'h0C);
        apb(1'b1, `PPOC_A_PWR, 32'h0);
        apb(1'b1, `PPOC_A_CHG, 32'h0);
        // Ganged mode: shared pin powers and senses every port
        apb(1'b1, `PPOC_A_CTRL, 32'h1);
        hub_pwr_req <= 6'h01;
        @(posedge pclk);
        chk(32'({shared_power_pin_pu_en, shared_power_pin_oe_n,
                 port_control_pin_oe_n}), 32'hC0);
        wt(5);
        fault <= 7'h40;
        wt(7);
        chk(32'(oc_flag), 32'h3F);
        fault <= 7'h00;
        hub_oc_clr <= 6'h3F;
        @(posedge pclk);
        hub_oc_clr <= 6'h00;
        @(posedge pclk);
        chk(32'(oc_flag), 32'h0);
        // Power cycle rearms the gang detector; a reset then clears flags and pins and restores register reset values
        hub_pwr_req <= 6'h00;
        @(posedge pclk);
        hub_pwr_req <= 6'h01;
        wt(5);
        fault <= 7'h40;
        wt(7);
        chk(32'(oc_flag), 32'h3F);
        presetn     <= 1'b0;
        hub_pwr_req <= 6'h00;
        fault       <= 7'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(32'(oc_flag), 32'h0);
        chk(32'({shared_power_pin_oe_n, port_control_pin_oe_n}),
            32'h0);
        rchk(`PPOC_A_CTRL, 32'h0);
        rchk(`PPOC_A_LOCK, 32'h0A);
        report_and_stop();
    end
endmodule
